// file: inc/adc_ctrl_pkg.sv
// shared constants and types of the converter frame and trigger control
package adc_ctrl_pkg;
  // serial word and result layout
  localparam int WORD_W = 16;
  localparam int RESULT_W = 14;
  localparam int PAD_W = WORD_W - RESULT_W;
  localparam logic [PAD_W-1:0] PAD_FILL = 2'h0;
  // serial edge counter
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_CLEAR = 4'h0;
  localparam logic [CNT_W-1:0] CNT_LAST = 4'hF;
  // result buffer
  localparam int FIFO_DEPTH = 16;
  // conversion mode select
  localparam int MODE_W = 2;
  localparam logic [MODE_W-1:0] MODE_EOC = 2'h0;
  // synchronised pin vector layout
  localparam int PIN_W = 3;
  localparam int PIN_CS = 0;
  localparam int PIN_FS = 1;
  localparam int PIN_TRIG = 2;
  localparam logic [PIN_W-1:0] PIN_IDLE = 3'h7;
  // crossing-back vector layout
  localparam int BACK_W = 2;
  localparam int BACK_ACK = 0;
  localparam int BACK_RX = 1;
  // sample and hold sequencing
  typedef enum logic [1:0] {
    phase_idle,
    phase_sampling,
    phase_converting
  } conv_phase_t;
endpackage

// file: logic/bit_sync.sv
// two flip-flop synchroniser for a vector of independent levels
module bit_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // meta is read by stable only, never by logic
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  // shift the level through both stages
  always_comb begin
    next_st.meta = async_in;
    next_st.stable = st.meta;
    if (rst) begin
      next_st.meta = RESET_VAL;
      next_st.stable = RESET_VAL;
    end
  end

  // register the stages
  always_ff @(posedge clock) begin
    st <= next_st;
  end

  assign sync_out = st.stable;
endmodule

// file: logic/result_fifo.sv
// single-clock fifo with valid and ready on both sides
module result_fifo #(
  parameter int WIDTH = adc_ctrl_pkg::RESULT_W,
  parameter int DEPTH = adc_ctrl_pkg::FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  import adc_ctrl_pkg::*;

  localparam int PTR_W = $clog2(DEPTH);

  // pointers carry one extra wrap bit so full and empty differ
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W:0] wr_ptr;
    logic [PTR_W:0] rd_ptr;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic full;
  logic empty;
  logic push;
  logic pop;

  // occupancy flags from the pointers
  always_comb begin
    empty = st.wr_ptr == st.rd_ptr;
    full = (st.wr_ptr[PTR_W] != st.rd_ptr[PTR_W]) &&
           (st.wr_ptr[PTR_W-1:0] == st.rd_ptr[PTR_W-1:0]);
    push = in_valid && !full;
    pop = !empty && out_ready;
  end

  // write and read pointer update
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr_ptr[PTR_W-1:0]] = in_data;
      next_st.wr_ptr = st.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_st.rd_ptr = st.rd_ptr + 1'b1;
    end
    if (sys_rst) begin
      next_st = '0;
    end
  end

  // register the whole state
  always_ff @(posedge clock) begin
    st <= next_st;
  end

  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = st.mem[st.rd_ptr[PTR_W-1:0]];
endmodule

// file: logic/adc_frame_and_trigger_ctrl.sv
// frame start, serial gating, trigger sampling and status pin of the converter
// What this block does
// - select high: output floats, input and shifting ignored
// - select fall clears counter, drives output, enables input only with sync high
// - sync high at select fall starts cycle
// - sync low: next sync rise starts cycle
// - extended mode: trigger fall starts sampling
// - trigger rise holds sample, starts conversion
// - trigger acts regardless of clock, select, sync
// - status is end-of-conversion only in mode zero
// - end-of-conversion low from sampling end to ready
// - interrupt falls when result is ready
// - interrupt cleared by select fall, sync rise, trigger fall
// - sync-started cycle clears counter, enables serial pins
// - input ignored after sixteen edges or select rise
// - output floats after sixteenth edge of cycle
module adc_frame_and_trigger_ctrl (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic serial_clock,
  input wire logic device_select_n,
  input wire logic frame_sync_in,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe_n,
  input wire logic sample_trigger_n,
  input wire logic extended_sampling,
  input wire logic [adc_ctrl_pkg::MODE_W-1:0] conversion_mode,
  input wire logic auto_sample_end,
  input wire logic [adc_ctrl_pkg::RESULT_W-1:0] result_data,
  input wire logic result_valid,
  output logic result_ready,
  output logic sample_track,
  output logic sample_hold,
  output logic conversion_start,
  output logic status_n,
  output logic [adc_ctrl_pkg::WORD_W-1:0] command_word,
  output logic command_valid
);
  import adc_ctrl_pkg::*;

  // edge detectors shared by both domains
  function automatic logic fell(input logic prev, input logic now);
    fell = prev && !now;
  endfunction

  function automatic logic rose(input logic prev, input logic now);
    rose = !prev && now;
  endfunction

  // state of the logic that runs on the serial clock
  typedef struct packed {
    logic cs_prev; // select level at the previous serial edge
    logic fs_prev; // sync level at the previous serial edge
    logic fs_mode; // cycles in this selection start on sync rise
    logic active; // shifting in progress
    logic drive; // output released from high impedance
    logic [CNT_W-1:0] count; // serial edge counter
    logic [WORD_W-1:0] shift_out; // outgoing word, msb first
    logic [WORD_W-1:0] shift_in; // incoming command bits
    logic [WORD_W-1:0] held; // last result taken from the system side
    logic [WORD_W-1:0] rx_word; // completed command word
    logic ack; // toggles when a result word is taken
    logic rx_tgl; // toggles when a command word completes
  } link_state_t;

  // state of the logic that runs on the system clock
  typedef struct packed {
    logic [PIN_W-1:0] pins_prev; // synchronised pins, one cycle old
    conv_phase_t phase; // sample and hold sequencing
    logic status_n; // shared status pin level
    logic conv_start; // one-cycle conversion start
    logic [WORD_W-1:0] tx_word; // result word offered to the link
    logic req; // toggles when tx_word holds a new word
    logic rx_prev; // last seen command toggle
    logic [WORD_W-1:0] cmd_word; // command word in this domain
    logic cmd_valid; // one-cycle command strobe
  } sys_state_t;

  link_state_t link;
  link_state_t next_link;
  sys_state_t sys;
  sys_state_t next_sys;

  logic link_rst; // system reset as seen by the serial clock
  logic req_sync; // request toggle in the serial domain
  logic [PIN_W-1:0] pins; // synchronised select, sync and trigger
  logic [BACK_W-1:0] back; // ack and command toggles in system domain
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [RESULT_W-1:0] fifo_out_data;
  logic push_done; // a finished result enters the buffer

  // reset reaches the serial domain through its own synchroniser;
  // it only takes effect once the host runs the serial clock
  bit_sync #(
    .WIDTH(1),
    .RESET_VAL(1'b1)
  ) u_link_rst_sync (
    .clock(serial_clock),
    .rst(1'b0),
    .async_in(sys_rst),
    .sync_out(link_rst)
  );

  // request toggle crosses into the serial domain
  bit_sync #(
    .WIDTH(1),
    .RESET_VAL(1'b0)
  ) u_req_sync (
    .clock(serial_clock),
    .rst(link_rst),
    .async_in(sys.req),
    .sync_out(req_sync)
  );

  // pins and serial-domain toggles cross into the system domain
  bit_sync #(
    .WIDTH(PIN_W),
    .RESET_VAL(PIN_IDLE)
  ) u_pin_sync (
    .clock(clock),
    .rst(sys_rst),
    .async_in({sample_trigger_n, frame_sync_in, device_select_n}),
    .sync_out(pins)
  );

  bit_sync #(
    .WIDTH(BACK_W),
    .RESET_VAL('0)
  ) u_back_sync (
    .clock(clock),
    .rst(sys_rst),
    .async_in({link.rx_tgl, link.ack}),
    .sync_out(back)
  );

  // results wait here until a frame takes them; when frames stop the
  // buffer fills and result_ready stalls the converter
  result_fifo #(
    .WIDTH(RESULT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .sys_rst(sys_rst),
    .in_valid(result_valid),
    .in_ready(result_ready),
    .in_data(result_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // serial side: select and sync are sampled on the host's own clock,
  // so a frame is seen at the first rising serial edge after its start
  always_comb begin
    logic cs_fall;
    logic fs_rise;
    logic start;
    cs_fall = fell(link.cs_prev, device_select_n);
    fs_rise = rose(link.fs_prev, frame_sync_in);
    start = 1'b0;
    next_link = link;
    next_link.cs_prev = device_select_n;
    next_link.fs_prev = frame_sync_in;
    if (device_select_n) begin
      // deselected: no shifting, output floats
      next_link.active = 1'b0;
      next_link.drive = 1'b0;
      next_link.fs_mode = 1'b0;
    end else if (cs_fall) begin
      next_link.count = CNT_CLEAR;
      next_link.drive = 1'b1;
      next_link.active = 1'b0;
      if (frame_sync_in) begin
        start = 1'b1;
      end else begin
        next_link.fs_mode = 1'b1;
      end
    end else if (link.fs_mode && fs_rise) begin
      // a new sync rise restarts the cycle even mid-word
      start = 1'b1;
      next_link.drive = 1'b1;
    end else if (link.active) begin
      next_link.shift_in = {link.shift_in[WORD_W-2:0], serial_data_in};
      next_link.shift_out = {link.shift_out[WORD_W-2:0], 1'b0};
      next_link.count = link.count + 1'b1;
      if (link.count == CNT_LAST) begin
        // sixteenth edge: stop listening and float the output
        next_link.active = 1'b0;
        next_link.drive = 1'b0;
        next_link.rx_word = {link.shift_in[WORD_W-2:0], serial_data_in};
        next_link.rx_tgl = !link.rx_tgl;
      end
    end
    if (start) begin
      next_link.active = 1'b1;
      next_link.count = CNT_CLEAR;
      // tx_word is stable whenever the request is ahead of the ack
      if (req_sync != link.ack) begin
        next_link.held = sys.tx_word;
        next_link.ack = !link.ack;
      end
      next_link.shift_out = next_link.held;
    end
    if (link_rst) begin
      next_link = '0;
      next_link.cs_prev = 1'b1;
      next_link.fs_prev = 1'b1;
    end
  end

  // register the serial-side state
  always_ff @(posedge serial_clock) begin
    link <= next_link;
  end

  // output floats at once on select high, not a serial edge later
  assign serial_data_out = link.shift_out[WORD_W-1];
  assign serial_data_oe_n = device_select_n || !link.drive;

  // system side: trigger sequencing, status pin and word crossings
  always_comb begin
    logic trig_fall;
    logic trig_rise;
    logic cs_fall;
    logic fs_rise;
    logic eoc_mode;
    logic set_int;
    trig_fall = fell(sys.pins_prev[PIN_TRIG], pins[PIN_TRIG]);
    trig_rise = rose(sys.pins_prev[PIN_TRIG], pins[PIN_TRIG]);
    cs_fall = fell(sys.pins_prev[PIN_CS], pins[PIN_CS]);
    fs_rise = rose(sys.pins_prev[PIN_FS], pins[PIN_FS]);
    eoc_mode = conversion_mode == MODE_EOC;
    set_int = 1'b0;
    next_sys = sys;
    next_sys.pins_prev = pins;
    next_sys.conv_start = 1'b0;
    next_sys.cmd_valid = 1'b0;
    // select and sync levels play no part here
    unique case (sys.phase)
      phase_idle: begin
        if (extended_sampling && trig_fall) begin
          next_sys.phase = phase_sampling;
        end else if (!extended_sampling && auto_sample_end) begin
          next_sys.phase = phase_converting;
          next_sys.conv_start = 1'b1;
          if (eoc_mode) begin
            next_sys.status_n = 1'b0;
          end
        end
      end
      phase_sampling: begin
        // the low time of the trigger sets the sampling window
        if (trig_rise) begin
          next_sys.phase = phase_converting;
          next_sys.conv_start = 1'b1;
          if (eoc_mode) begin
            next_sys.status_n = 1'b0;
          end
        end
      end
      phase_converting: begin
        // trigger edges here are ignored; the host must wait
        if (push_done) begin
          next_sys.phase = phase_idle;
          if (eoc_mode) begin
            next_sys.status_n = 1'b1;
          end else begin
            set_int = 1'b1;
          end
        end
      end
    endcase
    if (!eoc_mode) begin
      if (cs_fall || fs_rise || trig_fall) begin
        next_sys.status_n = 1'b1;
      end
      // a result landing with a clear still raises the interrupt
      if (set_int) begin
        next_sys.status_n = 1'b0;
      end
    end
    // offer the next buffered result to the serial side
    if (fifo_out_valid && fifo_out_ready) begin
      next_sys.tx_word = {fifo_out_data, PAD_FILL};
      next_sys.req = !sys.req;
    end
    // completed command word; rx_word stays put for a whole frame
    if (back[BACK_RX] != sys.rx_prev) begin
      next_sys.rx_prev = back[BACK_RX];
      next_sys.cmd_word = link.rx_word;
      next_sys.cmd_valid = 1'b1;
    end
    if (sys_rst) begin
      next_sys = '0;
      next_sys.pins_prev = PIN_IDLE;
      next_sys.phase = phase_idle;
      next_sys.status_n = 1'b1;
    end
  end

  // register the system-side state
  always_ff @(posedge clock) begin
    sys <= next_sys;
  end

  // the buffer takes results in any phase; only one taken while converting ends the conversion
  assign push_done = result_valid && result_ready && (sys.phase == phase_converting);
  // take a new word only once the last one was acknowledged
  assign fifo_out_ready = sys.req == back[BACK_ACK];

  assign sample_track = sys.phase == phase_sampling;
  assign sample_hold = sys.phase == phase_converting;
  assign conversion_start = sys.conv_start;
  assign status_n = sys.status_n;
  assign command_word = sys.cmd_word;
  assign command_valid = sys.cmd_valid;
endmodule

// file: test/adc_ctrl_properties.sv
// port assertions and covers of the converter frame and trigger control
module adc_ctrl_checker (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic serial_clock,
  input wire logic device_select_n,
  input wire logic frame_sync_in,
  input wire logic serial_data_oe_n,
  input wire logic sample_trigger_n,
  input wire logic extended_sampling,
  input wire logic [adc_ctrl_pkg::MODE_W-1:0] conversion_mode,
  input wire logic result_valid,
  input wire logic result_ready,
  input wire logic sample_track,
  input wire logic sample_hold,
  input wire logic conversion_start,
  input wire logic status_n
);
  timeunit 1ns;
  timeprecision 100ps;
  import adc_ctrl_pkg::*;
  // status pin acts as interrupt in every mode but zero
  wire irq_mode = (conversion_mode != MODE_EOC);
  sel_float_a: assert property (
    @(posedge clock) disable iff (sys_rst) device_select_n |-> serial_data_oe_n)
    else $error("output driven while deselected");
  frame_drive_a: assert property (
    @(posedge serial_clock) disable iff (sys_rst) $fell(device_select_n) |=> !serial_data_oe_n [*4])
    else $error("output not driven after select fall");
  // the word is 16 edges long, the float shows at the edge after
  frame_float_a: assert property (
    @(posedge serial_clock) disable iff (sys_rst)
    $fell(device_select_n) && frame_sync_in |-> ##17 serial_data_oe_n)
    else $error("output still driven after word");
  start_pulse_a: assert property (
    @(posedge clock) disable iff (sys_rst) conversion_start |=> !conversion_start)
    else $error("start pulse too long");
  start_hold_a: assert property (
    @(posedge clock) disable iff (sys_rst) conversion_start |-> sample_hold && !sample_track)
    else $error("start without hold");
  eoc_start_a: assert property (
    @(posedge clock) disable iff (sys_rst) conversion_start && !irq_mode |-> !status_n)
    else $error("end of conversion not low at start");
  hold_stands_a: assert property (
    @(posedge clock) disable iff (sys_rst) sample_hold && !(result_valid && result_ready) |=> sample_hold)
    else $error("hold dropped without result");
  done_status_a: assert property (
    @(posedge clock) disable iff (sys_rst) $fell(sample_hold) |-> status_n == !irq_mode)
    else $error("status wrong at result");
  // trigger is resynchronised, so allow a few cycles
  trig_track_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    extended_sampling && !sample_hold && !sample_track && $fell(sample_trigger_n) |-> ##[1:4] sample_track)
    else $error("trigger fall did not start sampling");
  trig_clear_a: assert property (
    @(posedge clock) disable iff (sys_rst) irq_mode && !sample_hold && $fell(sample_trigger_n) |-> ##[1:4] status_n)
    else $error("interrupt not cleared by trigger");
  cover property (@(posedge clock) conversion_start);
  cover property (@(posedge clock) irq_mode && $fell(status_n));
  cover property (@(posedge clock) !result_ready);
endmodule
bind adc_frame_and_trigger_ctrl adc_ctrl_checker checker_inst (.clock, .sys_rst, .serial_clock, .device_select_n,
  .frame_sync_in, .serial_data_oe_n, .sample_trigger_n, .extended_sampling, .conversion_mode, .result_valid,
  .result_ready, .sample_track, .sample_hold, .conversion_start, .status_n);

// file: test/host_port_model.sv
// host serial port model: link frames and the external trigger
module host_port_model (
  output logic serial_clock,
  output logic device_select_n,
  output logic frame_sync_in,
  output logic serial_data_in,
  output logic sample_trigger_n,
  input wire logic serial_data_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // link clock stands low between frames
  initial begin
    serial_clock = 1'b0;
    device_select_n = 1'b1;
    frame_sync_in = 1'b1;
    serial_data_in = 1'b0;
    sample_trigger_n = 1'b1;
  end
  // one 15 ns period; lines only change while the clock is low
  task automatic tick();
    #3.75 serial_clock = 1'b1;
    #7.5 serial_clock = 1'b0;
    #3.75;
  endtask
  task automatic idle_ticks(input int n);
    repeat (n) tick();
  endtask
  // one word, started by select fall or by a later sync rise
  task automatic frame(input logic by_select, input logic [15:0] tx, output logic [15:0] rx);
    frame_sync_in = by_select;
    // select must be seen high first; a result offered while the clock
    // stood still needs two edges to cross into the link domain
    repeat (2) tick();
    device_select_n = 1'b0;
    if (!by_select) begin
      tick();
      frame_sync_in = 1'b1;
    end
    tick();
    for (int i = 15; i >= 0; i--) begin
      rx[i] = serial_data_out;
      serial_data_in = tx[i];
      tick();
    end
    tick(); // one edge past the word, still selected
    device_select_n = 1'b1;
    serial_data_in = ~tx[0]; // stale line shows the inverse
  endtask
  // the bench spaces the edges: long low, long high, after a frame
  task automatic trigger(input logic level);
    sample_trigger_n = level;
  endtask
endmodule

// file: test/test_adc_frame_and_trigger_ctrl.sv
// self-checking bench of the converter frame and trigger control
module test_adc_frame_and_trigger_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  import adc_ctrl_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic serial_clock, device_select_n, frame_sync_in, serial_data_in, sample_trigger_n;
  logic serial_data_out, serial_data_oe_n, sample_track, sample_hold, conversion_start, status_n;
  logic extended_sampling = 1'b1;
  logic auto_sample_end = 1'b0; // pulsed by the normal sampling scenario
  logic [MODE_W-1:0] conversion_mode = 2'h0;
  logic [RESULT_W-1:0] result_data = 14'h0000;
  logic result_valid = 1'b0;
  logic result_ready, command_valid;
  logic [WORD_W-1:0] command_word, got_cmd, rx;
  int fail_count = 0;
  int n_tests = 0;
  always #4 clock = ~clock;
  adc_frame_and_trigger_ctrl DUT (.clock, .sys_rst, .serial_clock, .device_select_n, .frame_sync_in,
    .serial_data_in, .serial_data_out, .serial_data_oe_n, .sample_trigger_n, .extended_sampling,
    .conversion_mode, .auto_sample_end, .result_data, .result_valid, .result_ready, .sample_track,
    .sample_hold, .conversion_start, .status_n, .command_word, .command_valid);
  host_port_model host (.serial_clock, .device_select_n, .frame_sync_in, .serial_data_in,
    .sample_trigger_n, .serial_data_out);
  // the word pulse is short, so latch it mid-cycle where it has settled
  always @(negedge clock) begin
    if (command_valid === 1'b1) got_cmd <= command_word;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (fail_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // inputs move 1 ns after the edge
  task automatic cycles(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wait_hi(ref logic s);
    for (int k = 0; k < 60 && s !== 1'b1; k++) cycles(1);
  endtask
  task automatic push(input logic [RESULT_W-1:0] d);
    result_data = d;
    result_valid = 1'b1;
    wait_hi(result_ready);
    cycles(1);
    result_valid = 1'b0;
    cycles(1); // let an edge pass before the next offer
  endtask
  task automatic link(input logic by_select, input logic [WORD_W-1:0] tx, input logic [RESULT_W-1:0] exp);
    host.frame(by_select, tx, rx);
    cycles(8);
    check(rx, {exp, PAD_FILL});
    check(got_cmd, tx);
  endtask
  // fill the buffer until refused, then drain it over the link;
  // one word waits in the hand-off register besides the buffer
  task automatic t_buffer();
    for (int i = 0; i <= FIFO_DEPTH; i++) push(14'h2A50 + 14'(i));
    result_data = 14'h3FFF;
    result_valid = 1'b1;
    cycles(3);
    check(result_ready, 1'b0);
    result_valid = 1'b0;
    for (int i = 0; i <= FIFO_DEPTH; i++) link(i[0], 16'hA5C3 ^ 16'(i), 14'h2A50 + 14'(i));
    // nothing new buffered: the last word goes out again, the refused one never
    link(1'b1, 16'h0F0F, 14'h2A50 + 14'(FIFO_DEPTH));
  endtask
  // without extended sampling the trigger starts no sampling or hold
  task automatic t_normal();
    extended_sampling = 1'b0;
    host.trigger(1'b0);
    cycles(6);
    check(sample_track, 1'b0);
    host.trigger(1'b1);
    cycles(6);
    check(sample_hold, 1'b0);
    extended_sampling = 1'b1;
  endtask
  task automatic t_conv(input logic [MODE_W-1:0] mode, input logic [RESULT_W-1:0] r);
    conversion_mode = mode;
    host.trigger(1'b0);
    wait_hi(sample_track);
    check(sample_track, 1'b1);
    check(status_n, 1'b1);
    cycles(20);
    host.trigger(1'b1);
    wait_hi(conversion_start);
    check(sample_hold, 1'b1);
    check(status_n, mode != MODE_EOC);
    cycles(5);
    check(sample_hold, 1'b1);
    push(r);
    cycles(2);
    check(sample_hold, 1'b0);
    check(status_n, mode == MODE_EOC);
  endtask
  // normal sampling: the converter's own sample end starts the conversion
  task automatic t_auto(input logic [RESULT_W-1:0] r);
    extended_sampling = 1'b0;
    conversion_mode = MODE_EOC;
    auto_sample_end = 1'b1;
    cycles(1);
    auto_sample_end = 1'b0;
    check(conversion_start, 1'b1);
    check(sample_hold, 1'b1);
    check(status_n, 1'b0);
    push(r);
    cycles(2);
    check(sample_hold, 1'b0);
    check(status_n, 1'b1);
    extended_sampling = 1'b1;
    link(1'b1, 16'hC3C3, r);
  endtask
  initial begin
    fork
      host.idle_ticks(3);
      cycles(6);
    join
    sys_rst = 1'b0;
    host.idle_ticks(3);
    check(serial_data_oe_n, 1'b1);
    check(status_n, 1'b1);
    t_buffer();
    t_normal();
    for (int m = 0; m < 4; m++) t_conv(2'(m), 14'h1C30 + 14'(m));
    link(1'b1, 16'h1234, 14'h1C30);
    check(status_n, 1'b1);
    for (int m = 1; m < 4; m++) link(m[0], 16'h5A00, 14'h1C30 + 14'(m));
    t_auto(14'h0E71);
    close_out();
  end
  // cut a hang short
  initial begin
    #200000;
    fail_count++;
    close_out();
  end
endmodule
